// ---- spl_defines.svh ----
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH
// ****************************************
// Widths and reset values
// ****************************************
`define SPL_WIDTH 8
`define SPL_STAGES_RESET 8'h00
`define SPL_SYNC_RESET 5'h00
`define SPL_PIN_COUNT 5
`endif

// ---- spl_pkg.sv ----
`include "spl_defines.svh"
package spl_pkg;
   typedef logic [`SPL_WIDTH-1:0] spl_byte_type;
   typedef struct packed
   {
      logic serial_data_in;
      logic shift_clock;
      logic shift_clear_n;
      logic storage_clock;
      logic storage_clear_n;
   } spl_pins_type;
endpackage : spl_pkg

// ---- spl_shift_latch.sv ----
`timescale 1ns/1ps
`include "spl_defines.svh"
module spl_shift_latch
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Host pins
   input wire spl_pkg::spl_pins_type pins_i,
   // Outputs
   output logic [`SPL_WIDTH-1:0] parallel_outputs_o,
   output logic cascade_serial_out_o
);
   import spl_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Each pin passes three flops; a level is accepted once the second and third agree.
   // A level shorter than about two clocks can vanish here, so the host must hold levels longer.
   logic [`SPL_PIN_COUNT-1:0] sync1;
   logic [`SPL_PIN_COUNT-1:0] sync2;
   logic [`SPL_PIN_COUNT-1:0] sync3;
   logic [`SPL_PIN_COUNT-1:0] pin_vec;
   logic [`SPL_PIN_COUNT-1:0] filt;
   wire logic [`SPL_PIN_COUNT-1:0] next_filt;
   assign pin_vec = pins_i;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sync1 <= `SPL_SYNC_RESET;
         sync2 <= `SPL_SYNC_RESET;
         sync3 <= `SPL_SYNC_RESET;
      end
      else
      begin
         sync1 <= pin_vec;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // A pin whose two last samples disagree keeps its previous accepted level.
   generate
      for (genvar i = 0; i < `SPL_PIN_COUNT; i++)
      begin : g_filter
         assign next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
      end
   endgenerate

   // Clears filter back to low after reset so the registers start cleared.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         filt <= `SPL_SYNC_RESET;
      else
         filt <= next_filt;
   end

   spl_pins_type pin;
   assign pin = filt;

   // ****************************************
   // Edge detection
   // ****************************************
   // Edges come from the filtered levels, so a clock pin must stand a few cycles to count.
   logic shift_clk_q;
   logic storage_clk_q;
   logic shift_edge;
   logic storage_edge;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         shift_clk_q <= 1'b0;
         storage_clk_q <= 1'b0;
      end
      else
      begin
         shift_clk_q <= pin.shift_clock;
         storage_clk_q <= pin.storage_clock;
      end
   end

   assign shift_edge = pin.shift_clock & ~shift_clk_q;
   assign storage_edge = pin.storage_clock & ~storage_clk_q;

   // ****************************************
   // Shift register
   // ****************************************
   spl_byte_type stages;
   spl_byte_type next_stages;
   assign next_stages = {stages[`SPL_WIDTH-2:0], pin.serial_data_in};

   // Reset stands in for the power-up clear that the host would otherwise give.
   // Clear wins over an edge in the same cycle, as the pin is a direct override.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         stages <= `SPL_STAGES_RESET;
      else if (!pin.shift_clear_n)
         stages <= `SPL_STAGES_RESET;
      else if (shift_edge)
         stages <= next_stages;
   end

   // ****************************************
   // Storage register
   // ****************************************
   // Storage reads stages before this cycle's shift, so common clocks lag by one.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         parallel_outputs_o <= `SPL_STAGES_RESET;
      else if (!pin.storage_clear_n)
         parallel_outputs_o <= `SPL_STAGES_RESET;
      else if (storage_edge)
         parallel_outputs_o <= stages;
   end

   // Cascade output is the last stage; the host chains it onward.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cascade_serial_out_o <= 1'b0;
      else if (!pin.shift_clear_n)
         cascade_serial_out_o <= 1'b0;
      else if (shift_edge)
         cascade_serial_out_o <= stages[`SPL_WIDTH-2];
   end

   // ****************************************
   // Checks
   // ****************************************
   a_shift_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !pin.shift_clear_n |=> stages == '0)
      else $error("shift stages not cleared");

   a_shift_moves: assert property (@(posedge clk_i) disable iff (rst_i)
      (shift_edge && pin.shift_clear_n) |=> stages == $past(next_stages))
      else $error("shift did not advance");

   a_shift_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (shift_edge && pin.shift_clear_n) |=> stages[0] == $past(pin.serial_data_in))
      else $error("first stage missed serial data");

   a_shift_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!shift_edge && pin.shift_clear_n) |=> $stable(stages))
      else $error("shift changed without edge");

   // A falling shift clock is an ordinary level change and must move nothing.
   a_shift_fall_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (!pin.shift_clock && shift_clk_q && pin.shift_clear_n) |=> $stable(stages))
      else $error("shift moved on falling clock");

   a_shift_edge_once: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_edge |=> !shift_edge)
      else $error("shift edge longer than one cycle");

   // ****************************************
   // Storage and cascade checks
   // ****************************************
   a_store_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (storage_edge && pin.storage_clear_n) |=> parallel_outputs_o == $past(stages))
      else $error("storage did not load");

   // With common clocks the new stages are the stored ones moved up by one place.
   a_store_lag: assert property (@(posedge clk_i) disable iff (rst_i)
      (storage_edge && shift_edge && pin.storage_clear_n && pin.shift_clear_n)
      |=> parallel_outputs_o[`SPL_WIDTH-2:0] == stages[`SPL_WIDTH-1:1])
      else $error("storage not one shift behind");

   a_store_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!storage_edge && pin.storage_clear_n) |=> $stable(parallel_outputs_o))
      else $error("storage changed without edge");

   a_store_shift_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (shift_edge && !storage_edge && pin.storage_clear_n) |=> $stable(parallel_outputs_o))
      else $error("storage moved while shifting");

   a_store_fall_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (!pin.storage_clock && storage_clk_q && pin.storage_clear_n)
      |=> $stable(parallel_outputs_o))
      else $error("storage moved on falling clock");

   a_store_edge_once: assert property (@(posedge clk_i) disable iff (rst_i)
      storage_edge |=> !storage_edge)
      else $error("storage edge longer than one cycle");

   a_store_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      !pin.storage_clear_n |=> parallel_outputs_o == '0)
      else $error("storage not cleared");

   a_cascade_last: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade_serial_out_o == stages[`SPL_WIDTH-1])
      else $error("cascade not last stage");

   a_cascade_shift: assert property (@(posedge clk_i) disable iff (rst_i)
      (shift_edge && pin.shift_clear_n)
      |=> cascade_serial_out_o == $past(stages[`SPL_WIDTH-2]))
      else $error("cascade did not follow shift");

   a_cascade_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!shift_edge && pin.shift_clear_n) |=> $stable(cascade_serial_out_o))
      else $error("cascade changed without edge");

   a_cascade_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      !pin.shift_clear_n |=> !cascade_serial_out_o)
      else $error("cascade not cleared");

   // ****************************************
   // Front end checks
   // ****************************************
   // A level in flux must never reach the edge detectors.
   a_filter_take: assert property (@(posedge clk_i) disable iff (rst_i)
      (sync2 == sync3) |=> filt == $past(sync3))
      else $error("filter missed an agreed level");

   a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (sync2 != sync3) |=> filt == $past(filt))
      else $error("filter took a level in flux");
endmodule : spl_shift_latch

// ---- spl_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Host pin driver
// ****************************************
module spl_host_model
(
   // Clock
   input wire logic clk_i,
   // Pins
   output spl_pkg::spl_pins_type pins_o
);
   import spl_pkg::*;
   initial pins_o = '0;
   // Each level stands seven cycles so the input filter never drops it.
   task automatic step(input spl_pins_type p);
      @(posedge clk_i);
      #1 pins_o = p;
      repeat (6) @(posedge clk_i);
   endtask : step
   task automatic pulse(input spl_pins_type p);
      step(p);
      step(5'h05);
   endtask : pulse
   task automatic clear_all();
      pulse(5'h00);
   endtask : clear_all
   // Released data is inverted so a late sample cannot pass by luck.
   task automatic send_bit(input logic d, input logic com);
      step({d, 4'h5});
      step({d, 2'h3, com, 1'b1});
      step({~d, 4'h5});
   endtask : send_bit
   task automatic send_byte(input spl_byte_type v);
      for (int i = 7; i >= 0; i--)
         send_bit(v[i], 1'b0);
   endtask : send_byte
endmodule : spl_host_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   import spl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   spl_pins_type pins;
   spl_byte_type par;
   logic casc;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   // ****************************************
   // Clock, device and host
   // ****************************************
   initial forever #2.5 clk_i = ~clk_i;
   spl_host_model u_spl_host_model (.clk_i(clk_i), .pins_o(pins));
   spl_shift_latch u_spl_shift_latch (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
      .parallel_outputs_o(par), .cascade_serial_out_o(casc));
   task automatic check(input string what, input logic [8:0] exp);
      // Look a little after the edge so the outputs launched on it have settled.
      #1;
      samples_checked++;
      if ({casc, par} !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, {casc, par});
      end
   endtask : check
   task automatic t_load();
      u_spl_host_model.clear_all();
      check("after clears", 9'h000);
      u_spl_host_model.send_byte(8'hA5);
      check("shift only", {1'b1, 8'h00});
      u_spl_host_model.pulse(5'h07);
      check("latched", {1'b1, 8'hA5});
      $display("test load done");
   endtask : t_load
   task automatic t_common();
      u_spl_host_model.pulse(5'h04);
      check("storage clear", {1'b1, 8'h00});
      u_spl_host_model.send_bit(1'b0, 1'b1);
      check("common clocks", {1'b0, 8'hA5});
      $display("test common done");
   endtask : t_common
   task automatic t_shift_clear();
      u_spl_host_model.pulse(5'h01);
      check("shift clear", {1'b0, 8'hA5});
      u_spl_host_model.pulse(5'h07);
      check("load cleared", 9'h000);
      $display("test shift clear done");
   endtask : t_shift_clear
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk_i);
      #1 rst_i = 1'b0;
      t_load();
      t_common();
      t_shift_clear();
      give_verdict();
   end
endmodule : tb
